// [core/ocd_map.svh]
// register offsets, field positions and reset values of the group dividers
// assumes: included by bare name from the divider design files
`ifndef OCD_MAP_SVH
`define OCD_MAP_SVH

`define G1_PERIOD_ADDR 12'h193
`define G1_CTRL_ADDR 12'h194
`define G1_POWER_ADDR 12'h195
`define G2_PERIOD_ADDR 12'h196
`define G2_CTRL_ADDR 12'h197
`define LOW_MSB 7
`define LOW_LSB 4
`define HIGH_MSB 3
`define HIGH_LSB 0
`define BYPASS_BIT 7
`define IGNORE_SYNC_BIT 6
`define FORCE_HIGH_BIT 5
`define START_HIGH_BIT 4
`define PHASE_MSB 3
`define PHASE_LSB 0
`define POWER_DOWN_BIT 2
`define DUTY_FIX_OFF_BIT 0
`define G1_PERIOD_RST 8'h33
`define G2_PERIOD_RST 8'h11
`define CTRL_RST 8'h00
`define POWER_RST 8'h00
`define POWER_MASK 8'h05
`define CALM_MIN 6'd40
`endif

// [core/ocd_pkg.sv]
// types shared by the group divider files
// assumes: compiled before every other design file
`default_nettype none
package ocd_pkg;
  typedef logic [7:0] reg_byte_t;
  typedef logic [11:0] reg_addr_t;
  typedef logic [3:0] count_t;
  typedef logic [4:0] reg_sel_t;
  typedef enum logic [1:0]
  {
    DIV_WAIT = 2'b00,
    DIV_RUN = 2'b01
  } div_state_e;
endpackage : ocd_pkg
`default_nettype wire

// [core/group_divider.sv]
// one group divider: counts low and high phases of the input clock
// assumes: settings come from registers in core_clk domain
`default_nettype none
`include "ocd_map.svh"
module group_divider
  import ocd_pkg::*;
(
  input wire logic core_clk,
  input wire logic reset,
  input wire count_t lowCount,
  input wire count_t highCount,
  input wire logic bypass,
  input wire logic ignoreSync,
  input wire logic forceHigh,
  input wire logic startHigh,
  input wire count_t phaseOffset,
  input wire logic chipSync,
  output logic divOut
);
  div_state_e state_q, state_d;
  count_t cnt_q, cnt_d;
  logic level_q, level_d;
  logic syncHit, forced;

  assign syncHit = chipSync && !ignoreSync;
  // force alone does nothing unless sync is ignored too
  assign forced = ignoreSync && forceHigh;
  assign divOut = level_q;

  always_comb
  begin
    state_d = state_q;
    cnt_d = cnt_q;
    level_d = level_q;
    if (forced)
    begin
      state_d = DIV_RUN;
      level_d = 1'b1;
      cnt_d = 4'h0;
    end
    else if (bypass)
    begin
      // counter idles; output toggles every input cycle, half the input clock rate
      state_d = DIV_RUN;
      level_d = ~level_q;
      cnt_d = 4'h0;
    end
    else if (syncHit && phaseOffset == 4'h0)
    begin
      state_d = DIV_RUN;
      level_d = startHigh;
      cnt_d = startHigh ? highCount : lowCount;
    end
    else if (syncHit)
    begin
      // opposite level is held so the waveform looks shifted
      state_d = DIV_WAIT;
      level_d = ~startHigh;
      cnt_d = phaseOffset - 4'h1;
    end
    else
    begin
      case (state_q)
        DIV_WAIT:
        begin
          if (cnt_q == 4'h0)
          begin
            state_d = DIV_RUN;
            level_d = startHigh;
            cnt_d = startHigh ? highCount : lowCount;
          end
          else
          begin
            cnt_d = cnt_q - 4'h1;
          end
        end
        default:
        begin
          if (cnt_q == 4'h0)
          begin
            level_d = ~level_q;
            cnt_d = level_q ? lowCount : highCount;
          end
          else
          begin
            cnt_d = cnt_q - 4'h1;
          end
        end
      endcase
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      state_q <= DIV_WAIT;
      cnt_q <= 4'h0;
      level_q <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      level_q <= level_d;
    end
  end

  a_bypass_toggle: assert property (
    @(posedge core_clk) disable iff (reset)
    bypass && !forced |=> divOut != $past(divOut))
    else $error("bypass output did not follow input clock");
  a_force_static: assert property (
    @(posedge core_clk) disable iff (reset)
    forced [*2] |-> divOut)
    else $error("forced output not held high");
  a_sync_ignored: assert property (
    @(posedge core_clk) disable iff (reset)
    chipSync && ignoreSync && !forceHigh && !bypass && cnt_q != 4'h0
    |=> cnt_q == $past(cnt_q) - 4'h1)
    else $error("ignored sync disturbed the count");
  a_sync_start: assert property (
    @(posedge core_clk) disable iff (reset)
    syncHit && !bypass && !forceHigh && phaseOffset == 4'h0
    |=> divOut == $past(startHigh) && state_q == DIV_RUN)
    else $error("restart did not apply start level");
  a_phase_hold: assert property (
    @(posedge core_clk) disable iff (reset)
    syncHit && !bypass && !forceHigh && phaseOffset == 4'h2 &&
    $stable(startHigh) ##1 !chipSync [*2]
    |=> divOut == $past(startHigh, 3))
    else $error("phase offset delay wrong");
endmodule : group_divider
`default_nettype wire

// [core/output_group_clock_divider.sv]
// register file, group 1 and group 2 dividers and group 1 output pairs
// assumes: register strobes and chip sync are synchronous to core_clk
`default_nettype none
`include "ocd_map.svh"
module output_group_clock_divider
  import ocd_pkg::*;
(
  input wire logic core_clk,
  input wire logic reset,
  input wire logic regWrite,
  input wire logic regRead,
  input wire reg_addr_t regAddr,
  input wire reg_byte_t regWrData,
  output logic [7:0] regRdData,
  input wire logic chipSync,
  output logic group1OutputAP,
  output logic group1OutputAN,
  output logic group1OutputAOe,
  output logic group1OutputBP,
  output logic group1OutputBN,
  output logic group1OutputBOe,
  output logic group1OutputCP,
  output logic group1OutputCN,
  output logic group1OutputCOe,
  output logic group1DutyFixOn,
  output logic group2Clk
);
  reg_byte_t g1Period_q, g1Period_d;
  reg_byte_t g1Ctrl_q, g1Ctrl_d;
  reg_byte_t g1Power_q, g1Power_d;
  reg_byte_t g2Period_q, g2Period_d;
  reg_byte_t g2Ctrl_q, g2Ctrl_d;
  reg_byte_t rdData_q, rdData_d;
  logic dutyFix_q, dutyFix_d;
  logic [2:0] pairP_q, pairP_d;
  logic [2:0] pairN_q, pairN_d;
  logic [2:0] pairOe_q, pairOe_d;
  reg_sel_t wrSel, rdSel;
  reg_byte_t period [2];
  reg_byte_t ctrl [2];
  logic [1:0] divOut;

  // one-hot select, shared by the write and read paths
  function automatic reg_sel_t selReg(input reg_addr_t a);
    reg_sel_t s;
    s = 5'h00;
    if (a == `G1_PERIOD_ADDR)
      s = 5'h01;
    else if (a == `G1_CTRL_ADDR)
      s = 5'h02;
    else if (a == `G1_POWER_ADDR)
      s = 5'h04;
    else if (a == `G2_PERIOD_ADDR)
      s = 5'h08;
    else if (a == `G2_CTRL_ADDR)
      s = 5'h10;
    return s;
  endfunction : selReg

  assign wrSel = regWrite ? selReg(regAddr) : 5'h00;
  assign rdSel = selReg(regAddr);

  always_comb
  begin
    g1Period_d = wrSel[0] ? regWrData : g1Period_q;
    g1Ctrl_d = wrSel[1] ? regWrData : g1Ctrl_q;
    // only power-down and duty-fix bits exist; the rest read zero
    g1Power_d = wrSel[2] ? (regWrData & `POWER_MASK) : g1Power_q;
    g2Period_d = wrSel[3] ? regWrData : g2Period_q;
    g2Ctrl_d = wrSel[4] ? regWrData : g2Ctrl_q;
    rdData_d = rdData_q;
    if (regRead)
    begin
      if (rdSel[0])
        rdData_d = g1Period_q;
      else if (rdSel[1])
        rdData_d = g1Ctrl_q;
      else if (rdSel[2])
        rdData_d = g1Power_q;
      else if (rdSel[3])
        rdData_d = g2Period_q;
      else if (rdSel[4])
        rdData_d = g2Ctrl_q;
      else
        rdData_d = 8'h00;
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      g1Period_q <= `G1_PERIOD_RST;
      g1Ctrl_q <= `CTRL_RST;
      g1Power_q <= `POWER_RST;
      g2Period_q <= `G2_PERIOD_RST;
      g2Ctrl_q <= `CTRL_RST;
      rdData_q <= 8'h00;
    end
    else
    begin
      g1Period_q <= g1Period_d;
      g1Ctrl_q <= g1Ctrl_d;
      g1Power_q <= g1Power_d;
      g2Period_q <= g2Period_d;
      g2Ctrl_q <= g2Ctrl_d;
      rdData_q <= rdData_d;
    end
  end

  assign period[0] = g1Period_q;
  assign period[1] = g2Period_q;
  assign ctrl[0] = g1Ctrl_q;
  assign ctrl[1] = g2Ctrl_q;

  for (genvar g = 0; g < 2; g++)
  begin : grp
    logic prev_q, prev_d;
    logic [4:0] run_q, run_d;
    logic [5:0] calm_q, calm_d;
    logic disturb;

    group_divider u_div (
      .core_clk(core_clk),
      .reset(reset),
      .lowCount(period[g][`LOW_MSB:`LOW_LSB]),
      .highCount(period[g][`HIGH_MSB:`HIGH_LSB]),
      .bypass(ctrl[g][`BYPASS_BIT]),
      .ignoreSync(ctrl[g][`IGNORE_SYNC_BIT]),
      .forceHigh(ctrl[g][`FORCE_HIGH_BIT]),
      .startHigh(ctrl[g][`START_HIGH_BIT]),
      .phaseOffset(ctrl[g][`PHASE_MSB:`PHASE_LSB]),
      .chipSync(chipSync),
      .divOut(divOut[g])
    );

    // helper logic for the phase-length checks only
    assign disturb = regWrite || chipSync || ctrl[g][`BYPASS_BIT] ||
      ctrl[g][`IGNORE_SYNC_BIT];
    always_comb
    begin
      prev_d = divOut[g];
      run_d = run_q;
      calm_d = calm_q;
      if (divOut[g] != prev_q)
        run_d = 5'h01;
      else if (run_q != 5'h1f)
        run_d = run_q + 5'h01;
      if (disturb)
        calm_d = 6'h00;
      else if (calm_q != 6'h3f)
        calm_d = calm_q + 6'h01;
    end

    always_ff @(posedge core_clk)
    begin
      if (reset)
      begin
        prev_q <= 1'b0;
        run_q <= 5'h00;
        calm_q <= 6'h00;
      end
      else
      begin
        prev_q <= prev_d;
        run_q <= run_d;
        calm_q <= calm_d;
      end
    end

    a_low_phase_len: assert property (@(posedge core_clk)
      disable iff (reset)
      calm_q >= `CALM_MIN && prev_q == 1'b0 && divOut[g]
      |-> run_q == {1'b0, period[g][`LOW_MSB:`LOW_LSB]} + 5'h01)
      else $error("low phase length wrong");
    a_high_phase_len: assert property (@(posedge core_clk)
      disable iff (reset)
      calm_q >= `CALM_MIN && prev_q && !divOut[g]
      |-> run_q == {1'b0, period[g][`HIGH_MSB:`HIGH_LSB]} + 5'h01)
      else $error("high phase length wrong");
  end

  always_comb
  begin
    // duty fixer is on while the disable bit is clear
    dutyFix_d = ~g1Power_q[`DUTY_FIX_OFF_BIT];
    for (int i = 0; i < 3; i++)
    begin
      // powered-down pairs drop output enable and drive both legs low
      pairOe_d[i] = ~g1Power_q[`POWER_DOWN_BIT];
      pairP_d[i] = pairOe_d[i] & divOut[0];
      pairN_d[i] = pairOe_d[i] & ~divOut[0];
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      dutyFix_q <= 1'b1;
      pairOe_q <= 3'h0;
      pairP_q <= 3'h0;
      pairN_q <= 3'h0;
    end
    else
    begin
      dutyFix_q <= dutyFix_d;
      pairOe_q <= pairOe_d;
      pairP_q <= pairP_d;
      pairN_q <= pairN_d;
    end
  end

  assign regRdData = rdData_q;
  assign group1DutyFixOn = dutyFix_q;
  assign group2Clk = divOut[1];
  assign group1OutputAP = pairP_q[0];
  assign group1OutputAN = pairN_q[0];
  assign group1OutputAOe = pairOe_q[0];
  assign group1OutputBP = pairP_q[1];
  assign group1OutputBN = pairN_q[1];
  assign group1OutputBOe = pairOe_q[1];
  assign group1OutputCP = pairP_q[2];
  assign group1OutputCN = pairN_q[2];
  assign group1OutputCOe = pairOe_q[2];

  a_power_down: assert property (
    @(posedge core_clk) disable iff (reset)
    g1Power_q[`POWER_DOWN_BIT]
    |=> pairOe_q == 3'h0 && pairP_q == 3'h0 && pairN_q == 3'h0)
    else $error("powered-down pairs still driven");
  a_duty_fix: assert property (
    @(posedge core_clk) disable iff (reset)
    $rose(g1Power_q[`DUTY_FIX_OFF_BIT]) |-> ##1 !group1DutyFixOn)
    else $error("duty fixer not switched off");
  a_period_reset: assert property (@(posedge core_clk)
    $fell(reset) |-> g1Period_q == `G1_PERIOD_RST)
    else $error("group 1 period reset value wrong");
endmodule : output_group_clock_divider
`default_nettype wire

// [testbench/clock_sink.sv]
// partner: clock receiver that measures the last low and high run lengths
// assumes: clkIn is sampled on the divider input clock
`default_nettype none
module clock_sink
(
  input wire logic core_clk,
  input wire logic clkIn,
  output int lowLen,
  output int highLen
);
  timeunit 1ns;
  timeprecision 100ps;
  logic lastQ = 1'b0;
  int runQ = 0;
  // case inequality so a change to or from an unknown level restarts the run
  always @(posedge core_clk)
  begin
    lastQ <= clkIn;
    runQ <= (clkIn !== lastQ) ? 1 : runQ + 1;
    if (clkIn !== lastQ && lastQ === 1'b1)
      highLen <= runQ;
    if (clkIn !== lastQ && lastQ === 1'b0)
      lowLen <= runQ;
  end
endmodule : clock_sink
`default_nettype wire

// [testbench/testbench.sv]
// self-checking bench of the group divider block
// assumes: design files and clock_sink are compiled before it
`default_nettype none
module testbench;
  import ocd_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;
  logic core_clk = 1'b0;
  logic reset = 1'b1;
  logic regWrite = 1'b0;
  logic regRead = 1'b0;
  reg_addr_t regAddr = 12'h000;
  reg_byte_t regWrData = 8'h00;
  logic chipSync = 1'b0;
  logic [7:0] regRdData;
  logic aP, aOe, bOe, cOe, dutyOn, g2Clk;
  logic aN, bP, bN, cP, cN;
  int lowG1, highG1, lowG2, highG2;
  int miscompares = 0;
  int checkCount = 0;
  logic [31:0] seed = 32'h2f92;
  logic [7:0] per;
  logic [3:0] off;
  logic [7:0] rstVal [6] = '{8'h33, 8'h00, 8'h00, 8'h11, 8'h00, 8'h00};
  always #2 core_clk = ~core_clk;

  output_group_clock_divider i_output_group_clock_divider
  (
    .core_clk(core_clk), .reset(reset), .regWrite(regWrite),
    .regRead(regRead), .regAddr(regAddr), .regWrData(regWrData),
    .regRdData(regRdData), .chipSync(chipSync), .group1OutputAP(aP),
    .group1OutputAN(aN), .group1OutputAOe(aOe), .group1OutputBP(bP),
    .group1OutputBN(bN), .group1OutputBOe(bOe), .group1OutputCP(cP),
    .group1OutputCN(cN), .group1OutputCOe(cOe),
    .group1DutyFixOn(dutyOn), .group2Clk(g2Clk)
  );
  clock_sink sinkG1(.core_clk(core_clk), .clkIn(aP), .lowLen(lowG1),
    .highLen(highG1));
  clock_sink sinkG2(.core_clk(core_clk), .clkIn(g2Clk), .lowLen(lowG2),
    .highLen(highG2));

  function automatic logic [31:0] xorshift(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction : xorshift

  // a count field of n means a phase of n plus one input cycles
  function automatic logic [7:0] phaseLen(input logic [3:0] f);
    return {4'h0, f} + 8'h01;
  endfunction : phaseLen

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checkCount++;
    if (got !== exp)
    begin
      miscompares++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input reg_addr_t a, input reg_byte_t d);
    @(posedge core_clk);
    regWrite <= 1'b1;
    regAddr <= a;
    regWrData <= d;
    @(posedge core_clk);
    regWrite <= 1'b0;
  endtask : wr

  task automatic rd(input reg_addr_t a, input reg_byte_t e);
    @(posedge core_clk);
    regRead <= 1'b1;
    regAddr <= a;
    @(posedge core_clk);
    regRead <= 1'b0;
    @(posedge core_clk);
    #1 chk(regRdData, e);
  endtask : rd

  // returns at the edge where the sync pulse is taken
  task automatic syn;
    @(posedge core_clk);
    chipSync <= 1'b1;
    @(posedge core_clk);
    chipSync <= 1'b0;
  endtask : syn

  task automatic runs(input logic [7:0] p, input int n);
    repeat (n) @(posedge core_clk);
    #1;
    chk(8'(lowG2), phaseLen(p[7:4]));
    chk(8'(highG2), phaseLen(p[3:0]));
  endtask : runs

  task automatic stopTest;
    $display("checks %0d mismatches %0d", checkCount, miscompares);
    if (miscompares == 0 && checkCount > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : stopTest

  initial
  begin
    repeat (12) @(posedge core_clk);
    reset <= 1'b0;
    wr(12'h198, 8'hff);
    for (int i = 0; i < 6; i++)
      rd(12'h193 + 12'(i), rstVal[i]);
    chk({4'h0, aOe, bOe, cOe, dutyOn}, 8'h0f);
    syn();
    repeat (20) @(posedge core_clk);
    #1 chk(8'(lowG1), 8'h04);
    chk(8'(highG1), 8'h04);
    // all three pairs carry the group 1 clock while powered
    for (int i = 0; i < 8; i++)
    begin
      chk({3'h0, aN, bP, bN, cP, cN},
        {3'h0, ~aP, aP, ~aP, aP, ~aP});
      @(posedge core_clk);
      #1;
    end
    $display("reset values done");
    for (int k = 0; k < 6; k++)
    begin
      seed = xorshift(seed);
      per = (k == 0) ? 8'h00 : (k == 1) ? 8'hff : seed[7:0];
      wr(12'h196, per);
      rd(12'h196, per);
      syn();
      runs(per, 70);
    end
    $display("periods done");
    wr(12'h196, 8'h11);
    for (int k = 0; k < 4; k++)
    begin
      off = (k == 0) ? 4'h0 : (k == 1) ? 4'h5 : (k == 2) ? 4'hf : 4'h2;
      wr(12'h197, {3'b000, k[0], off});
      syn();
      for (int i = 0; i <= off + 1; i++)
      begin
        #1 chk({7'h0, g2Clk}, {7'h0, k[0] ^ (i < off)});
        @(posedge core_clk);
      end
    end
    $display("start level and offset done");
    // a sync every third cycle would pin the low phase if obeyed
    wr(12'h196, 8'h23);
    wr(12'h197, 8'h40);
    for (int i = 0; i < 10; i++)
    begin
      syn();
      @(posedge core_clk);
    end
    #1 chk(8'(lowG2), 8'h03);
    chk(8'(highG2), 8'h04);
    wr(12'h197, 8'h60);
    syn();
    for (int i = 0; i < 10; i++)
    begin
      #1 chk({7'h0, g2Clk}, 8'h01);
      @(posedge core_clk);
    end
    wr(12'h197, 8'h80);
    runs(8'h00, 12);
    $display("ignore, force and bypass done");
    wr(12'h195, 8'hff);
    rd(12'h195, 8'h05);
    chk({4'h0, aOe, bOe, cOe, dutyOn}, 8'h00);
    chk({2'h0, aP, aN, bP, bN, cP, cN}, 8'h00);
    $display("power down done");
    stopTest();
  end

  initial
  begin
    repeat (20000) @(posedge core_clk);
    miscompares++;
    stopTest();
  end
endmodule : testbench
`default_nettype wire
